// ==== bench/rct_partner.sv ====
// Far-side model: drives the count and trigger pins and counts baud ticks.
// Assumes the bench resolves the shared count pin from the timer's output enable.
`default_nettype none

module rct_partner (
    // Clock.
    input wire logic sys_clk_i,
    // Pins driven towards the timer.
    output logic count_pin_o,
    output logic trigger_pin_o,
    // Serial port clocks.
    input wire logic rx_tick_i,
    input wire logic tx_tick_i
);
    timeunit 1ns;
    timeprecision 1ps;
    int rx_seen = 0;
    int tx_seen = 0;
    initial count_pin_o = 1'b1;
    initial trigger_pin_o = 1'b1;

    // The serial port only takes single-cycle ticks.
    always @(posedge sys_clk_i) begin
        rx_seen += int'(rx_tick_i);
        tx_seen += int'(tx_tick_i);
    end

    // Gives one clean 1-to-0 edge; the timer sees it at the second clock edge.
    task fall(input logic trig);
        @(posedge sys_clk_i);
        if (trig) begin
            trigger_pin_o <= 1'b0;
        end else begin
            count_pin_o <= 1'b0;
        end
        @(posedge sys_clk_i);
        count_pin_o <= 1'b1;
        trigger_pin_o <= 1'b1;
        @(posedge sys_clk_i);
    endtask : fall

    // Sets the direction level of the trigger pin.
    task level(input logic v);
        @(posedge sys_clk_i);
        trigger_pin_o <= v;
    endtask : level
endmodule : rct_partner

`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench for the reloadable capture timer.
// Assumes the register map and reset values of the shared package.
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rct_pkg::*;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic irq_en;
    logic other_tick;
    logic [7:0] rdata;
    logic [7:0] b;
    logic cp_o, cp_oe, p_cnt, p_trig, irq, rx_t, tx_t;
    wire logic cp_wire;
    logic [15:0] v, w;
    int err_total = 0;
    int checks_done = 0;
    int toggles = 0;
    int others = 0;
    int m_rld;
    integer seed = 32'h3faf5a7c;

    assign cp_wire = cp_oe ? cp_o : p_cnt;
    initial forever #10 sys_clk_i = ~sys_clk_i;
    always @(cp_o) toggles++;
    always @(posedge sys_clk_i) others += int'(other_tick);

    rct_timer i_rct_timer (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata),
        .count_pin_i(cp_wire), .count_pin_o(cp_o), .count_pin_oe_o(cp_oe),
        .trigger_pin_i(p_trig), .irq_enable_i(irq_en), .timer_irq_o(irq),
        .other_timer_tick_i(other_tick), .rx_baud_tick_o(rx_t), .tx_baud_tick_o(tx_t));
    rct_partner i_rct_partner (.sys_clk_i(sys_clk_i), .count_pin_o(p_cnt),
        .trigger_pin_o(p_trig), .rx_tick_i(rx_t), .tx_tick_i(tx_t));

    // ========================================================================
    // Bus and comparison tasks.
    // ========================================================================
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    task near(input int seen, input int exp);
        chk({15'h0, seen >= exp - 1 && seen <= exp + 1}, 16'h0001);
    endtask : near

    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr <= 1'b0;
    endtask : wr

    task rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd <= 1'b0;
        #1 d = rdata;
    endtask : rd

    task wr16(input logic [2:0] a, input logic [15:0] d);
        wr(a, d[7:0]);
        wr(3'(a + 3'h1), d[15:8]);
    endtask : wr16

    task rd16(input logic [2:0] a, output logic [15:0] d);
        logic [7:0] lo, hi;
        rd(a, lo);
        rd(3'(a + 3'h1), hi);
        d = {hi, lo};
    endtask : rd16

    task ctrl_is(input logic [7:0] exp);
        rd(REG_CTRL, b);
        chk({8'h00, b}, {8'h00, exp});
    endtask : ctrl_is

    task summarize;
        $display("errors %0d, checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    // ========================================================================
    // Scenarios.
    // ========================================================================
    initial begin
        reg_addr <= 3'h0;
        reg_wdata <= 8'h00;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        irq_en <= 1'b1;
        other_tick <= 1'b0;
        repeat (10) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        for (int a = 0; a < 8; a++) begin
            rd(3'(a), b);
            chk({8'h00, b}, 16'h0000);
        end
        for (int i = 0; i < 4; i++) begin
            m_rld = $random(seed);
            wr16(REG_RLD_LO, m_rld[15:0]);
            rd16(REG_RLD_LO, v);
            chk(v, m_rld[15:0]);
        end
        // Counter mode: one pin edge at all ones overflows and reloads.
        wr16(REG_RLD_LO, 16'h1234);
        wr16(REG_CNT_LO, 16'hffff);
        wr(REG_CTRL, 8'h06);
        i_rct_partner.fall(1'b0);
        rd16(REG_CNT_LO, v);
        chk(v, 16'h1234);
        ctrl_is(8'h86);
        chk({15'h0, irq}, 16'h0001);
        wr(REG_CTRL, 8'h0e);
        #1 chk({15'h0, irq}, 16'h0000);
        wr16(REG_CNT_LO, 16'h5555);
        i_rct_partner.fall(1'b1);
        rd16(REG_CNT_LO, v);
        chk(v, 16'h1234);
        ctrl_is(8'h4e);
        chk({15'h0, irq}, 16'h0001);
        irq_en <= 1'b0;
        @(posedge sys_clk_i);
        #1 chk({15'h0, irq}, 16'h0000);
        irq_en <= 1'b1;
        // Capture mode: trigger copies the count, rollover wraps and flags.
        wr(REG_CTRL, 8'h0f);
        wr16(REG_CNT_LO, 16'habcd);
        i_rct_partner.fall(1'b1);
        rd16(REG_RLD_LO, v);
        chk(v, 16'habcd);
        rd16(REG_CNT_LO, v);
        chk(v, 16'habcd);
        wr16(REG_CNT_LO, 16'hffff);
        i_rct_partner.fall(1'b0);
        rd16(REG_CNT_LO, v);
        chk(v, 16'h0000);
        ctrl_is(8'hcf);
        // Up/down mode with the trigger pin as direction.
        wr(REG_CTRL, 8'h06);
        wr(REG_MODE, 8'h01);
        wr16(REG_RLD_LO, 16'h4000);
        wr16(REG_CNT_LO, 16'h4000);
        i_rct_partner.level(1'b0);
        i_rct_partner.fall(1'b0);
        rd16(REG_CNT_LO, v);
        chk(v, 16'hffff);
        ctrl_is(8'hc6);
        wr(REG_CTRL, 8'h46);
        #1 chk({15'h0, irq}, 16'h0000);
        i_rct_partner.level(1'b1);
        i_rct_partner.fall(1'b0);
        rd16(REG_CNT_LO, v);
        chk(v, 16'h4000);
        ctrl_is(8'h86);
        // Timer mode counts every 12 clocks; run clear freezes the count.
        wr(REG_MODE, 8'h00);
        wr16(REG_CNT_LO, 16'h0000);
        wr(REG_CTRL, 8'h04);
        repeat (118) @(posedge sys_clk_i);
        wr(REG_CTRL, 8'h00);
        rd16(REG_CNT_LO, v);
        near(int'(v), 10);
        repeat (40) @(posedge sys_clk_i);
        rd16(REG_CNT_LO, w);
        chk(w, v);
        // Baud generation: rollover every 2 ticks of 2 clocks.
        wr16(REG_RLD_LO, 16'hfffe);
        // Start next to the top so the first rollover comes within the window.
        wr16(REG_CNT_LO, 16'hfffe);
        wr(REG_CTRL, 8'h34);
        i_rct_partner.rx_seen = 0;
        i_rct_partner.tx_seen = 0;
        repeat (80) @(posedge sys_clk_i);
        near(i_rct_partner.rx_seen, 20);
        near(i_rct_partner.tx_seen, 20);
        ctrl_is(8'h34);
        wr(REG_CTRL, 8'h24);
        repeat (4) @(posedge sys_clk_i);
        i_rct_partner.tx_seen = 0;
        others = 0;
        repeat (30) begin
            @(posedge sys_clk_i);
            other_tick <= 1'($random(seed));
        end
        @(posedge sys_clk_i);
        other_tick <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        chk(16'(i_rct_partner.tx_seen), 16'(others));
        // Clock-out alone, then together with the transmit baud clock.
        wr(REG_MODE, 8'h02);
        wr(REG_CTRL, 8'h04);
        #1 chk({15'h0, cp_oe}, 16'h0001);
        toggles = 0;
        repeat (80) @(posedge sys_clk_i);
        near(toggles, 20);
        ctrl_is(8'h04);
        wr(REG_CTRL, 8'h14);
        toggles = 0;
        i_rct_partner.tx_seen = 0;
        repeat (80) @(posedge sys_clk_i);
        near(toggles, 20);
        near(i_rct_partner.tx_seen, 20);
        summarize();
    end

    initial begin
        repeat (20000) @(posedge sys_clk_i);
        err_total++;
        summarize();
    end
endmodule : tb

`default_nettype wire

// ==== hw/rct_fall_det.sv ====
// Falling edge detector for a synchronous input.
// Assumes the input is already synchronous to sys_clk_i.
`default_nettype none

module rct_fall_det (
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Level in, pulse out.
    input wire logic level_i,
    output logic fall_o
);

    logic prev_ff;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= level_i;
        end
    end

    // A high seen in reset does not count as an edge until it is sampled.
    assign fall_o = prev_ff & ~level_i;

endmodule : rct_fall_det

`default_nettype wire

// ==== hw/rct_prescaler.sv ====
// Free-running divider giving one tick every DIV clocks.
// Assumes DIV is at least 2.
`default_nettype none

module rct_prescaler import rct_pkg::*; #(
    parameter logic [3:0] DIV = DIV_TIMER
) (
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Tick out.
    output logic tick_o
);

    logic [3:0] cnt_ff;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || tick_o) begin
            cnt_ff <= 4'h0;
        end else begin
            cnt_ff <= cnt_ff + 4'h1;
        end
    end

    assign tick_o = (cnt_ff == DIV - 4'h1);

endmodule : rct_prescaler

`default_nettype wire

// ==== hw/rct_timer.sv ====
// Reloadable capture timer: 16-bit timer/counter with capture, auto-reload,
// baud clock generation and clock-out.
// Assumes synchronous pins, a 50 MHz clock used as the oscillator, and a
// serial port that takes the baud ticks only in its modes 1 and 3.
`default_nettype none

module rct_timer import rct_pkg::*; (
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Register port.
    input wire logic [2:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // Count pin (input for counting, output for clock-out).
    input wire logic count_pin_i,
    output logic count_pin_o,
    output logic count_pin_oe_o,
    // Trigger and direction pin.
    input wire logic trigger_pin_i,
    // Interrupt.
    input wire logic irq_enable_i,
    output logic timer_irq_o,
    // Serial port clocks.
    input wire logic other_timer_tick_i,
    output logic rx_baud_tick_o,
    output logic tx_baud_tick_o
);

    // ========================================================================
    // State and decode signals.
    // ========================================================================
    rct_ctrl_s ctrl_ff;
    rct_mode_s mode_ff;
    logic [15:0] cnt_ff;
    logic [15:0] rld_ff;
    logic clk_pin_ff;
    logic rx_tick_ff;
    logic tx_tick_ff;
    logic [7:0] rdata_ff;
    rct_mode_e mode;
    logic tick12;
    logic tick2;
    logic trig_fall;
    logic cpin_fall;
    logic updown;
    logic fast;
    logic tick;
    logic inc;
    logic dir_up;
    logic roll;
    logic under;
    logic trig_ev;
    logic cap_ev;
    logic trig_rld;
    logic ovf_set;
    logic ext_tgl;
    logic clk_out_act;
    logic cnt_wr;
    logic rld_wr;

    rct_prescaler #(.DIV(DIV_TIMER)) u_div_timer (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .tick_o(tick12)
    );

    rct_prescaler #(.DIV(DIV_BAUD)) u_div_baud (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .tick_o(tick2)
    );

    rct_fall_det u_trig_edge (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .level_i(trigger_pin_i),
        .fall_o(trig_fall)
    );

    rct_fall_det u_cpin_edge (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .level_i(count_pin_i),
        .fall_o(cpin_fall)
    );

    // ========================================================================
    // Mode decode.
    // ========================================================================
    always_comb begin
        if (!ctrl_ff.run_control) begin
            mode = MODE_OFF;
        end else if (ctrl_ff.rx_clock_select || ctrl_ff.tx_clock_select) begin
            mode = MODE_BAUD;
        end else if (clk_out_act) begin
            mode = MODE_CLKOUT;
        end else if (ctrl_ff.capture_reload_select) begin
            mode = MODE_CAPTURE;
        end else begin
            mode = MODE_RELOAD;
        end
    end

    assign clk_out_act = mode_ff.clock_out_enable & ~ctrl_ff.counter_timer_select;
    assign updown = (mode == MODE_RELOAD) & mode_ff.down_count_enable;
    // Baud and clock-out both step every state time, unless counter select takes count pin edges.
    assign fast = (mode == MODE_BAUD) || (mode == MODE_CLKOUT);
    always_comb begin
        case (1'b1)
            ctrl_ff.counter_timer_select: tick = cpin_fall;
            fast: tick = tick2;
            default: tick = tick12;
        endcase
    end
    assign inc = (mode != MODE_OFF) & tick;
    assign dir_up = ~updown | trigger_pin_i;
    assign roll = inc & dir_up & (cnt_ff == CNT_ALL_ONES);
    assign under = inc & ~dir_up & (cnt_ff == rld_ff);
    // In up/down mode the trigger pin steers direction and has no edge function.
    assign trig_ev = trig_fall & ctrl_ff.external_enable & ~updown & (mode != MODE_OFF);
    assign cap_ev = trig_ev & (mode == MODE_CAPTURE);
    assign trig_rld = trig_ev & (mode == MODE_RELOAD);
    // Baud and clock-out rollovers never flag.
    assign ovf_set = (roll | under) & ((mode == MODE_CAPTURE) || (mode == MODE_RELOAD));
    assign ext_tgl = updown & (roll | under);
    assign cnt_wr = reg_wr_i && ((reg_addr_i == REG_CNT_LO) || (reg_addr_i == REG_CNT_HI));
    assign rld_wr = reg_wr_i && ((reg_addr_i == REG_RLD_LO) || (reg_addr_i == REG_RLD_HI));

    // ========================================================================
    // Counter.
    // ========================================================================
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            cnt_ff <= CNT_RST;
        end else if (cnt_wr) begin
            cnt_ff <= rct_byte_put(cnt_ff, reg_addr_i == REG_CNT_HI, reg_wdata_i);
        end else if (under) begin
            cnt_ff <= CNT_ALL_ONES;
        end else if ((roll && (mode != MODE_CAPTURE)) || trig_rld) begin
            cnt_ff <= rld_ff;
        end else if (inc) begin
            cnt_ff <= cnt_ff + CNT_STEP;
        end
    end

    // ========================================================================
    // Capture/reload pair. A capture wins over a software write.
    // ========================================================================
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            rld_ff <= RLD_RST;
        end else if (cap_ev) begin
            rld_ff <= cnt_ff;
        end else if (rld_wr) begin
            rld_ff <= rct_byte_put(rld_ff, reg_addr_i == REG_RLD_HI, reg_wdata_i);
        end
    end

    // ========================================================================
    // Control register with flags. Later assignments give set priority.
    // ========================================================================
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            ctrl_ff <= rct_ctrl_s'(CTRL_RST);
        end else begin
            if (reg_wr_i && (reg_addr_i == REG_CTRL)) begin
                ctrl_ff <= rct_ctrl_s'(reg_wdata_i);
            end
            if (ovf_set) begin
                ctrl_ff.overflow_flag <= 1'b1;
            end
            if (trig_ev) begin
                ctrl_ff.external_flag <= 1'b1;
            end else if (ext_tgl) begin
                ctrl_ff.external_flag <= ~ctrl_ff.external_flag;
            end
        end
    end

    // ========================================================================
    // Mode register; reserved bits read as zero.
    // ========================================================================
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            mode_ff <= rct_mode_s'(MODE_RST);
        end else if (reg_wr_i && (reg_addr_i == REG_MODE)) begin
            mode_ff.clock_out_enable <= reg_wdata_i[1];
            mode_ff.down_count_enable <= reg_wdata_i[0];
        end
    end

    // ========================================================================
    // Clock-out: toggling on each rollover halves the rollover rate.
    // ========================================================================
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || !clk_out_act) begin
            clk_pin_ff <= 1'b0;
        end else if (roll) begin
            clk_pin_ff <= ~clk_pin_ff;
        end
    end

    assign count_pin_o = clk_pin_ff;
    assign count_pin_oe_o = clk_out_act;

    // ========================================================================
    // Serial port clock selection.
    // ========================================================================
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            rx_tick_ff <= 1'b0;
            tx_tick_ff <= 1'b0;
        end else begin
            rx_tick_ff <= ctrl_ff.rx_clock_select ? (roll & (mode == MODE_BAUD))
                                                  : other_timer_tick_i;
            tx_tick_ff <= ctrl_ff.tx_clock_select ? (roll & (mode == MODE_BAUD))
                                                  : other_timer_tick_i;
        end
    end

    assign rx_baud_tick_o = rx_tick_ff;
    assign tx_baud_tick_o = tx_tick_ff;

    // The up/down toggle of the external flag does not interrupt while up/down mode is active.
    assign timer_irq_o = irq_enable_i &
                         (ctrl_ff.overflow_flag | (ctrl_ff.external_flag & ~updown));

    // ========================================================================
    // Read data, valid only in the cycle after the read strobe.
    // ========================================================================
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || !reg_rd_i) begin
            rdata_ff <= RDATA_IDLE;
        end else begin
            case (reg_addr_i)
                REG_CTRL: rdata_ff <= ctrl_ff;
                REG_MODE: rdata_ff <= mode_ff;
                REG_CNT_LO: rdata_ff <= rct_byte_get(cnt_ff, 1'b0);
                REG_CNT_HI: rdata_ff <= rct_byte_get(cnt_ff, 1'b1);
                REG_RLD_LO: rdata_ff <= rct_byte_get(rld_ff, 1'b0);
                REG_RLD_HI: rdata_ff <= rct_byte_get(rld_ff, 1'b1);
                default: rdata_ff <= RDATA_IDLE;
            endcase
        end
    end

    assign reg_rdata_o = rdata_ff;

    // ========================================================================
    // Assertions and covers.
    // ========================================================================
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    ovf_flag_set_a: assert property (
        ovf_set |=> ctrl_ff.overflow_flag)
        else $error("overflow flag not set after rollover");

    capture_copy_a: assert property (
        cap_ev |=> (rld_ff == $past(cnt_ff)) && ctrl_ff.external_flag)
        else $error("capture did not copy count or set external flag");

    capture_keeps_a: assert property (
        (mode == MODE_CAPTURE) && inc && !cnt_wr |=> cnt_ff == $past(cnt_ff) + CNT_STEP)
        else $error("capture mode disturbed the count");

    reload_on_ovf_a: assert property (
        (mode == MODE_RELOAD) && roll && !cnt_wr && !rld_wr |=> cnt_ff == $past(rld_ff))
        else $error("auto-reload did not load the reload pair");

    down_underflow_a: assert property (
        under && !cnt_wr |=> (cnt_ff == CNT_ALL_ONES) && ctrl_ff.overflow_flag)
        else $error("underflow did not load all ones and flag");

    ext_toggle_a: assert property (
        ext_tgl |=> ctrl_ff.external_flag != $past(ctrl_ff.external_flag))
        else $error("external flag did not toggle on wrap");

    baud_no_flag_a: assert property (
        (mode == MODE_BAUD) && !ctrl_ff.overflow_flag && !reg_wr_i
        |=> !ctrl_ff.overflow_flag)
        else $error("overflow flag set in baud mode");

    updown_no_irq_a: assert property (
        updown && !ctrl_ff.overflow_flag |-> !timer_irq_o)
        else $error("external flag interrupted in up/down mode");

    down_count_enable_reset_a: assert property (
        $past(sys_rst_i) |-> !mode_ff.down_count_enable && !ctrl_ff.run_control)
        else $error("down count enable not clear after reset");

    clkout_toggle_a: assert property (
        clk_out_act && roll ##1 clk_out_act |-> count_pin_o != $past(count_pin_o))
        else $error("clock-out did not toggle on rollover");

    rx_select_a: assert property (
        !ctrl_ff.rx_clock_select |=> rx_baud_tick_o == $past(other_timer_tick_i))
        else $error("receive clock not taken from other timer");

    read_latency_a: assert property (
        reg_rd_i && (reg_addr_i == REG_CNT_HI) |=> reg_rdata_o == $past(cnt_ff[15:8]))
        else $error("count high byte read back wrong");

    capture_seen_c: cover property (cap_ev);
    underflow_seen_c: cover property (under);
    clkout_seen_c: cover property (clk_out_act && roll);
    baud_tick_seen_c: cover property (tx_baud_tick_o && ctrl_ff.tx_clock_select);

endmodule : rct_timer

`default_nettype wire

// ==== shared/rct_pkg.sv ====
// Constants, register map and carrier types for the reloadable capture timer.
// Assumes one 50 MHz system clock that stands in for the oscillator.
`default_nettype none

package rct_pkg;

    // ========================================================================
    // Register map (byte registers on a 3-bit register index).
    // ========================================================================
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_MODE = 3'h1;
    localparam logic [2:0] REG_CNT_LO = 3'h2;
    localparam logic [2:0] REG_CNT_HI = 3'h3;
    localparam logic [2:0] REG_RLD_LO = 3'h4;
    localparam logic [2:0] REG_RLD_HI = 3'h5;

    // ========================================================================
    // Reset values and count constants.
    // ========================================================================
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] RDATA_IDLE = 8'h00;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] RLD_RST = 16'h0000;
    localparam logic [15:0] CNT_ALL_ONES = 16'hffff;
    localparam logic [15:0] CNT_STEP = 16'h0001;

    // Oscillator divisors: machine cycle for timing, state time for baud and clock-out.
    localparam logic [3:0] DIV_TIMER = 4'hc;
    localparam logic [3:0] DIV_BAUD = 4'h2;

    // ========================================================================
    // Carrier types.
    // ========================================================================
    typedef struct packed {
        logic overflow_flag;
        logic external_flag;
        logic rx_clock_select;
        logic tx_clock_select;
        logic external_enable;
        logic run_control;
        logic counter_timer_select;
        logic capture_reload_select;
    } rct_ctrl_s;

    typedef struct packed {
        logic [5:0] reserved;
        logic clock_out_enable;
        logic down_count_enable;
    } rct_mode_s;

    typedef enum {
        MODE_OFF,
        MODE_RELOAD,
        MODE_CAPTURE,
        MODE_BAUD,
        MODE_CLKOUT
    } rct_mode_e;

    // Replaces one byte of a 16-bit register.
    function automatic logic [15:0] rct_byte_put(input logic [15:0] cur, input logic hi,
                                                 input logic [7:0] data);
        rct_byte_put = hi ? {data, cur[7:0]} : {cur[15:8], data};
    endfunction : rct_byte_put

    // Selects one byte of a 16-bit register.
    function automatic logic [7:0] rct_byte_get(input logic [15:0] val, input logic hi);
        rct_byte_get = hi ? val[15:8] : val[7:0];
    endfunction : rct_byte_get

endpackage : rct_pkg

`default_nettype wire
